//--- logic/activation_limiter.sv
// counts activations per window and blocks past four per limit step
// assumes window_start_i and activate_i come from core-clock logic
`timescale 1ns/100ps
`default_nettype none
module activation_limiter
  import mem_throttle_pkg::*;
#(
  parameter int count_width = 10
)
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // sync reset, high
  input wire logic window_start_i, // new activation window
  input wire logic activate_i, // one activation issued
  input wire logic [7:0] limit_i, // active throttle value
  output logic block_o // stop further activations
);
  logic [count_width-1:0] count;
  logic [count_width-1:0] next_count;

  // refuse a counter too narrow for the full bandwidth figure
  if (count_width < 10)
  begin : width_check
    $error("count_width too small for 672 activations");
  end

  // zero is unlimited, each step is four activations
  function automatic logic [count_width-1:0] allowed(input logic [7:0] v);
    allowed = count_width'({v, 2'b00});
  endfunction

  always_comb
  begin
    next_count = count;
    if (window_start_i)
      next_count = '0;
    else if (activate_i && !block_o)
      next_count = count + count_width'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      count <= '0;
    else
      count <= next_count;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      block_o <= 1'b0;
    else
      block_o <= (limit_i != 8'h00_00) && (next_count >= allowed(limit_i)); // R16 R2
  end

  unlimited_block_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (limit_i == 8'h00_00) |=> !block_o) else $error("block with unlimited value"); // R2
  block_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
    block_o |-> (count >= allowed($past(limit_i)))) else $error("early block"); // R16
endmodule
`default_nettype wire

//--- logic/capped_limit_reg.sv
// one 8-bit throttle limit register that saturates writes at the cap
// assumes the write strobe is one cycle wide on the core clock
`timescale 1ns/100ps
`default_nettype none
module capped_limit_reg
  import mem_throttle_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic reset_i, // sync reset, high
  input wire logic wr_i, // write this register
  input wire logic [7:0] data_i, // written value
  output logic [7:0] value_o // stored limit
);
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      value_o <= limit_reset;
    else if (wr_i)
      value_o <= (data_i > limit_cap) ? limit_cap : data_i; // R3
  end

  capped_range_a: assert property (@(posedge clk_i) disable iff (reset_i)
    value_o <= limit_cap) else $error("limit above cap"); // R3
endmodule
`default_nettype wire

//--- logic/mem_throttle_config_regs.sv
// throttle limits, throttle control, misc memory control and clock ratio bank
// assumes temperature zone, global window and activation inputs are on clk_i
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: mid limit applies in mid temperature range when enabled, or on global throttle.
// R2: limits are 8 bits, four activations per step, zero unlimited, 168 full.
// R3: writes above 168 are stored as 168.
// R4: software keeps mid no larger than low and high no larger than mid.
// R5: with step select set, high limit applies above mid temperature.
// R6: with step select clear, high limit bounds the hunting value.
// R7: above mid with global throttle, the stronger throttle wins.
// R8: high-level throttling only while temperature throttling is enabled.
// R9: control bit 1 picks staircase stepping or slam to high limit.
// R10: with enable clear, only the global throttle changes the value.
// R11: starvation timeout is eight cycles per step plus eight, up to 128.
// R12: single channel bit 14 restricts operation to branch 0 channel 0.
// R13: present ratio reports 00 one to one, 10 four five, 11 five four.
// R14: sticky next ratio moves into present ratio at hard reset.
// R15: low limit applies below low threshold or when both controls are clear.
// R16: activations per window are blocked at four times the active value.
module mem_throttle_config_regs
  import mem_throttle_pkg::*;
(
  input wire logic clk_i, // core clock, 10 MHz
  input wire logic reset_i, // hard reset, sync, high
  input wire logic cold_reset_i, // power-up reset, sync, high
  input wire logic [7:0] addr_i, // register offset
  input wire logic [31:0] wr_data_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  input wire logic [1:0] temp_zone_i, // 0 low, 1 mid, 2 above mid
  input wire logic global_window_throttle_i, // open loop throttle request
  input wire logic window_start_i, // activation window boundary
  input wire logic activate_i, // memory activation issued
  output logic [31:0] rd_data_o, // read data, cycle after rd_i
  output logic [7:0] active_throttle_value_o, // limit in force
  output logic activation_block_o, // activations stopped this window
  output logic [7:0] starvation_delay_o, // scheduler timeout in cycles
  output logic single_channel_select_o, // one channel operation
  output logic [1:0] present_ratio_o // core to memory ratio now
);
  logic [7:0] low_throttle_limit;
  logic [7:0] mid_throttle_limit;
  logic [7:0] high_throttle_limit;
  logic throttle_step_select;
  logic temperature_throttle_enable;
  logic [3:0] starvation_timeout;
  logic [1:0] next_ratio;
  logic [7:0] stair_value;
  logic [7:0] next_active;
  logic [31:0] read_word;
  logic wr_ctrl;
  logic wr_misc;
  logic wr_ratio;
  step_type step_state;

  assign wr_ctrl = wr_i && (addr_i == throttle_control_offset);
  assign wr_misc = wr_i && (addr_i == memory_control_offset);
  assign wr_ratio = wr_i && (addr_i == clock_ratio_offset);

  // lower nonzero value throttles harder; zero means no limit
  function automatic logic [7:0] stronger(input logic [7:0] a, input logic [7:0] b);
    if (a == 8'h00_00)
      stronger = b;
    else if (b == 8'h00_00)
      stronger = a;
    else
      stronger = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] delay_cycles(input logic [3:0] t);
    logic [4:0] steps;
    steps = {1'b0, t} + 5'h01;
    delay_cycles = {steps, timeout_step_shift};
  endfunction

  capped_limit_reg low_reg (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_i(wr_i && (addr_i == low_limit_offset)),
    .data_i(wr_data_i[7:0]),
    .value_o(low_throttle_limit)
  );

  capped_limit_reg mid_reg (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_i(wr_i && (addr_i == mid_limit_offset)),
    .data_i(wr_data_i[7:0]),
    .value_o(mid_throttle_limit)
  );

  capped_limit_reg high_reg (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr_i(wr_i && (addr_i == high_limit_offset)),
    .data_i(wr_data_i[7:0]),
    .value_o(high_throttle_limit)
  );

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      throttle_step_select <= 1'b0;
      temperature_throttle_enable <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      throttle_step_select <= wr_data_i[mode_bit]; // R9
      temperature_throttle_enable <= wr_data_i[hunt_bit]; // R10
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      starvation_timeout <= timeout_reset;
      single_channel_select_o <= 1'b0;
    end
    else if (wr_misc)
    begin
      starvation_timeout <= wr_data_i[timeout_msb:timeout_lsb];
      single_channel_select_o <= wr_data_i[single_channel_bit]; // R12
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      starvation_delay_o <= delay_cycles(timeout_reset);
    else
      starvation_delay_o <= delay_cycles(starvation_timeout); // R11
  end

  // next ratio survives hard reset; only a power-up reset clears it
  always_ff @(posedge clk_i)
  begin
    if (cold_reset_i)
      next_ratio <= ratio_one_to_one;
    else if (wr_ratio && (wr_data_i[ratio_next_lsb +: 2] != ratio_reserved))
      next_ratio <= wr_data_i[ratio_next_lsb +: 2]; // R14
  end

  always_ff @(posedge clk_i)
  begin
    if (cold_reset_i)
      present_ratio_o <= ratio_one_to_one;
    else if (reset_i)
      present_ratio_o <= next_ratio; // R14 R13
  end

  // staircase hunting: start at mid, step one toward high per window
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      step_state <= step_off;
      stair_value <= limit_reset;
    end
    else
    begin
      case (step_state)
        step_off:
        begin
          if (temperature_throttle_enable && !throttle_step_select
              && (temp_zone_i == zone_high))
          begin
            step_state <= step_hunt;
            stair_value <= mid_throttle_limit;
          end
        end
        step_hunt:
        begin
          if (!temperature_throttle_enable || throttle_step_select
              || (temp_zone_i != zone_high))
            step_state <= step_off;
          else if (stair_value == 8'h00_00 && high_throttle_limit != 8'h00_00)
            stair_value <= high_throttle_limit; // R6
          else if (window_start_i && (stair_value > high_throttle_limit))
            stair_value <= stair_value - 8'h01; // R6
          else if (stair_value < high_throttle_limit)
            stair_value <= high_throttle_limit; // R6
        end
        default:
          step_state <= step_off;
      endcase
    end
  end

  always_comb
  begin
    next_active = low_throttle_limit; // R15
    if (!temperature_throttle_enable)
    begin
      if (global_window_throttle_i)
        next_active = mid_throttle_limit; // R10 R1
    end
    else
    begin
      case (temp_zone_i)
        zone_low:
          if (global_window_throttle_i)
            next_active = mid_throttle_limit; // R1
        zone_mid:
          next_active = mid_throttle_limit; // R1
        zone_high:
        begin
          if (throttle_step_select)
            next_active = high_throttle_limit; // R5 R8
          else if (step_state == step_hunt)
            next_active = stair_value; // R9
          else
            next_active = mid_throttle_limit; // R9
          if (global_window_throttle_i)
            next_active = stronger(next_active, mid_throttle_limit); // R7
        end
        default:
          next_active = mid_throttle_limit;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      active_throttle_value_o <= limit_reset;
    else
      active_throttle_value_o <= next_active;
  end

  activation_limiter #(
    .count_width(10)
  ) limiter (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .window_start_i(window_start_i),
    .activate_i(activate_i),
    .limit_i(active_throttle_value_o),
    .block_o(activation_block_o)
  );

  always_comb
  begin
    read_word = 32'h0000_0000;
    case (addr_i)
      low_limit_offset:
        read_word[7:0] = low_throttle_limit;
      mid_limit_offset:
        read_word[7:0] = mid_throttle_limit;
      high_limit_offset:
        read_word[7:0] = high_throttle_limit;
      throttle_control_offset:
      begin
        read_word[mode_bit] = throttle_step_select;
        read_word[hunt_bit] = temperature_throttle_enable;
      end
      memory_control_offset:
      begin
        read_word[timeout_msb:timeout_lsb] = starvation_timeout;
        read_word[single_channel_bit] = single_channel_select_o;
      end
      clock_ratio_offset:
      begin
        read_word[ratio_now_lsb +: 2] = present_ratio_o; // R13
        read_word[ratio_next_lsb +: 2] = next_ratio;
      end
      default:
        read_word = 32'h0000_0000;
    endcase
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rd_data_o <= 32'h0000_0000;
    else if (rd_i)
      rd_data_o <= read_word;
    else
      rd_data_o <= 32'h0000_0000;
  end

  mid_cap_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (wr_i && addr_i == mid_limit_offset && wr_data_i[7:0] > limit_cap)
    |=> (mid_throttle_limit == limit_cap))
    else $error("mid limit not capped"); // R3

  low_default_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!temperature_throttle_enable && !global_window_throttle_i)
    |=> (active_throttle_value_o == $past(low_throttle_limit)))
    else $error("low limit not applied"); // R15

  global_mid_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!temperature_throttle_enable && global_window_throttle_i)
    |=> (active_throttle_value_o == $past(mid_throttle_limit)))
    else $error("global throttle not mid"); // R1

  no_temp_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (!temperature_throttle_enable && temp_zone_i == zone_high
     && !global_window_throttle_i)
    |=> (active_throttle_value_o == $past(low_throttle_limit)))
    else $error("temperature acted while disabled"); // R10 R8

  slam_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (temperature_throttle_enable && throttle_step_select
     && temp_zone_i == zone_high && !global_window_throttle_i)
    |=> (active_throttle_value_o == $past(high_throttle_limit)))
    else $error("high limit not slammed"); // R5

  stronger_wins_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (temperature_throttle_enable && throttle_step_select
     && temp_zone_i == zone_high && global_window_throttle_i)
    |=> (active_throttle_value_o
         == stronger($past(high_throttle_limit), $past(mid_throttle_limit))))
    else $error("weaker throttle applied"); // R7

  stair_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (step_state == step_hunt && high_throttle_limit != 8'h00_00)
    ##1 (step_state == step_hunt && $stable(high_throttle_limit))
    |-> (stair_value >= high_throttle_limit))
    else $error("hunt passed high ceiling"); // R6

  timeout_range_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_misc ##2 !$past(wr_misc)
    |-> (starvation_delay_o
         == ({4'h0, $past(wr_data_i[timeout_msb:timeout_lsb], 2)} + 8'h01) * 8'h08))
    else $error("timeout delay wrong"); // R11

  single_chan_a: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_misc |=> (single_channel_select_o == $past(wr_data_i[single_channel_bit])))
    else $error("single channel bit lost"); // R12

  ratio_load_a: assert property (@(posedge clk_i) disable iff (cold_reset_i)
    (reset_i && !$past(wr_ratio)) ##1 reset_i
    |-> (present_ratio_o == $past(next_ratio)))
    else $error("ratio not loaded at reset"); // R14
endmodule
`default_nettype wire

//--- logic/mem_throttle_pkg.sv
// constants shared by the throttle configuration bank and its helpers
// assumes a single core clock and a synchronous reset
`default_nettype none
package mem_throttle_pkg;
  localparam logic [7:0] low_limit_offset = 8'h64;
  localparam logic [7:0] mid_limit_offset = 8'h65;
  localparam logic [7:0] high_limit_offset = 8'h66;
  localparam logic [7:0] throttle_control_offset = 8'h67;
  localparam logic [7:0] memory_control_offset = 8'h58;
  localparam logic [7:0] clock_ratio_offset = 8'h68;
  localparam logic [7:0] limit_cap = 8'h00_a8;
  localparam logic [7:0] limit_reset = 8'h00_00;
  localparam int activations_per_step = 4;
  localparam int mode_bit = 1;
  localparam int hunt_bit = 0;
  localparam int timeout_msb = 31;
  localparam int timeout_lsb = 28;
  localparam int single_channel_bit = 14;
  localparam int ratio_now_lsb = 4;
  localparam int ratio_next_lsb = 0;
  localparam logic [3:0] timeout_reset = 4'h0;
  localparam logic [1:0] ratio_one_to_one = 2'h0;
  localparam logic [1:0] ratio_reserved = 2'h1;
  localparam logic [1:0] ratio_four_five = 2'h2;
  localparam logic [1:0] ratio_five_four = 2'h3;
  localparam logic [1:0] zone_low = 2'h0;
  localparam logic [1:0] zone_mid = 2'h1;
  localparam logic [1:0] zone_high = 2'h2;
  localparam logic [2:0] timeout_step_shift = 3'h0;
  typedef enum logic [0:0] {step_off, step_hunt} step_type;
endpackage
`default_nettype wire

//--- sim/mem_throttle_config_regs_test.sv
// self-checking bench for the throttle configuration bank
// assumes reads answer one cycle after the strobe and outputs settle two edges after a change
`timescale 1ns/100ps
`default_nettype none
module mem_throttle_config_regs_test;
  import mem_throttle_pkg::*;
  logic clk_i = 1'h0;
  logic reset_i = 1'h1;
  logic cold_reset_i = 1'h1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0000_0000;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [1:0] temp_zone_i = 2'h0;
  logic global_window_throttle_i = 1'h0;
  logic window_start_i = 1'h0;
  logic activate_i = 1'h0;
  logic [31:0] rd_data_o;
  logic [7:0] active_throttle_value_o;
  logic activation_block_o;
  logic [7:0] starvation_delay_o;
  logic single_channel_select_o;
  logic [1:0] present_ratio_o;
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] got;
  logic [7:0] lim_addr [3];
  // ctrl nibble, zone nibble, global nibble, expected limit byte
  logic [19:0] sel_table [9];

  always #50 clk_i = ~clk_i;

  mem_throttle_config_regs dut (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cold_reset_i(cold_reset_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .temp_zone_i(temp_zone_i),
    .global_window_throttle_i(global_window_throttle_i),
    .window_start_i(window_start_i),
    .activate_i(activate_i),
    .rd_data_o(rd_data_o),
    .active_throttle_value_o(active_throttle_value_o),
    .activation_block_o(activation_block_o),
    .starvation_delay_o(starvation_delay_o),
    .single_channel_select_o(single_channel_select_o),
    .present_ratio_o(present_ratio_o)
  );

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      mismatches++;
    end
  endtask

  task automatic give_verdict;
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // one idle cycle between strobes keeps each strobe assigned once per step
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'h1;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clk_i);
    rd_i <= 1'h0;
    @(negedge clk_i);
    got = rd_data_o;
    check(got, e);
  endtask

  task automatic drive(input logic [1:0] zone, input logic gw);
    @(posedge clk_i);
    temp_zone_i <= zone;
    global_window_throttle_i <= gw;
    settle();
  endtask

  task automatic pulse_window;
    @(posedge clk_i);
    window_start_i <= 1'h1;
    @(posedge clk_i);
    window_start_i <= 1'h0;
    settle();
  endtask

  task automatic activate_for(input int n);
    @(posedge clk_i);
    activate_i <= 1'h1;
    repeat (n) @(posedge clk_i);
    activate_i <= 1'h0;
    settle();
  endtask

  task automatic hard_reset;
    @(posedge clk_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'h0;
    @(negedge clk_i);
  endtask

  initial
  begin
    lim_addr = '{low_limit_offset, mid_limit_offset, high_limit_offset};
    sel_table = '{20'h0_000a, 20'h0_200a, 20'h0_2106, 20'h3_000a,
                  20'h3_0106, 20'h3_1006, 20'h3_3006, 20'h3_2003, 20'h3_2103};
    repeat (20) @(posedge clk_i);
    reset_i <= 1'h0;
    cold_reset_i <= 1'h0;
    read_check(mid_limit_offset, 32'h0000_0000);
    read_check(throttle_control_offset, 32'h0000_0000);
    read_check(memory_control_offset, 32'h0000_0000);
    read_check(clock_ratio_offset, 32'h0000_0000);
    read_check(8'h70, 32'h0000_0000);
    for (int i = 0; i < 3; i++)
    begin
      reg_write(lim_addr[i], 32'h0000_00a9);
      read_check(lim_addr[i], 32'h0000_00a8);
      reg_write(lim_addr[i], 32'h0000_00a8);
      read_check(lim_addr[i], 32'h0000_00a8);
      reg_write(lim_addr[i], 32'hffff_ffff);
      read_check(lim_addr[i], 32'h0000_00a8);
    end
    reg_write(throttle_control_offset, 32'h0000_00ff);
    read_check(throttle_control_offset, 32'h0000_0003);
    reg_write(memory_control_offset, 32'hffff_ffff);
    read_check(memory_control_offset, 32'hf000_4000);
    settle();
    check({31'h0000_0000, single_channel_select_o}, 32'h0000_0001);
    for (int t = 0; t < 16; t++)
    begin
      reg_write(memory_control_offset, {t[3:0], 28'h000_0000});
      settle();
      check({24'h00_0000, starvation_delay_o}, 32'((t + 1) * 8));
      check({31'h0000_0000, single_channel_select_o}, 32'h0000_0000);
    end
    reg_write(low_limit_offset, 32'h0000_000a);
    reg_write(mid_limit_offset, 32'h0000_0006);
    reg_write(high_limit_offset, 32'h0000_0003);
    foreach (sel_table[k])
    begin
      reg_write(throttle_control_offset, {28'h000_0000, sel_table[k][19:16]});
      drive(sel_table[k][13:12], sel_table[k][8]);
      check({24'h00_0000, active_throttle_value_o}, {24'h00_0000, sel_table[k][7:0]});
    end
    // unlimited high is weaker than any nonzero mid
    reg_write(high_limit_offset, 32'h0000_0000);
    drive(2'h2, 1'h1);
    check({24'h00_0000, active_throttle_value_o}, 32'h0000_0006);
    reg_write(high_limit_offset, 32'h0000_0003);
    drive(2'h0, 1'h0);
    reg_write(throttle_control_offset, 32'h0000_0001);
    drive(2'h2, 1'h0);
    check({24'h00_0000, active_throttle_value_o}, 32'h0000_0006);
    pulse_window();
    check({24'h00_0000, active_throttle_value_o}, 32'h0000_0005);
    repeat (3) pulse_window();
    check({24'h00_0000, active_throttle_value_o}, 32'h0000_0003);
    drive(2'h0, 1'h0);
    reg_write(throttle_control_offset, 32'h0000_0000);
    reg_write(low_limit_offset, 32'h0000_0001);
    pulse_window();
    activate_for(3);
    check({31'h0000_0000, activation_block_o}, 32'h0000_0000);
    activate_for(1);
    check({31'h0000_0000, activation_block_o}, 32'h0000_0001);
    pulse_window();
    check({31'h0000_0000, activation_block_o}, 32'h0000_0000);
    reg_write(low_limit_offset, 32'h0000_0000);
    pulse_window();
    activate_for(8);
    check({31'h0000_0000, activation_block_o}, 32'h0000_0000);
    reg_write(clock_ratio_offset, 32'h0000_0002);
    read_check(clock_ratio_offset, 32'h0000_0002);
    check({30'h0000_0000, present_ratio_o}, 32'h0000_0000);
    hard_reset();
    check({30'h0000_0000, present_ratio_o}, 32'h0000_0002);
    read_check(clock_ratio_offset, 32'h0000_0022);
    read_check(mid_limit_offset, 32'h0000_0000);
    reg_write(clock_ratio_offset, 32'h0000_0001);
    read_check(clock_ratio_offset, 32'h0000_0022);
    reg_write(clock_ratio_offset, 32'h0000_0033);
    hard_reset();
    read_check(clock_ratio_offset, 32'h0000_0033);
    reg_write(clock_ratio_offset, 32'h0000_0000);
    hard_reset();
    check({30'h0000_0000, present_ratio_o}, 32'h0000_0000);
    give_verdict();
  end

  // hang guard well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
